// ===== hw/flash_guard_host.sv
// Host controller for flash boot-sector guard and secured region access
`timescale 1ns/1ps
module flash_guard_host (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic                                req_valid,
  input  wire logic [2:0]                          req_op,
  input  wire logic [flash_guard_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [flash_guard_pkg::DATA_W-1:0]  req_data,
  input  wire logic                                guard_enable,
  input  wire logic                                top_boot,
  output logic                                     req_ready,
  output logic                                     resp_valid,
  output logic [flash_guard_pkg::DATA_W-1:0]       resp_data,
  output logic                                     refused,
  output logic                                     in_region,
  output logic                                     factory_locked,
  output logic [flash_guard_pkg::ADDR_W-1:0]       flash_addr,
  input  wire logic [flash_guard_pkg::DATA_W-1:0]  dq_in,
  output logic [flash_guard_pkg::DATA_W-1:0]       dq_out,
  output logic                                     dq_oe,
  output logic                                     chip_en_n,
  output logic                                     write_en_n,
  output logic                                     out_en_n,
  output logic                                     boot_guard_accel_pin,
  output logic                                     flash_reset_n
);
  // Operations: 0 read, 1 write word, 2 enter region, 3 exit region,
  // 4 lock region, 5 read indicator
  typedef enum logic [2:0] {S_POWER, S_IDLE, S_SEQ, S_WAIT, S_DONE} state_e;
  typedef struct packed {
    state_e                                 state;
    logic [2:0]                             op;
    logic [2:0]                             step;
    logic                                   region;
    logic                                   locked_fac;
    logic                                   refused;
    logic                                   resp;
    logic [flash_guard_pkg::DATA_W-1:0]     data;
    logic [flash_guard_pkg::ADDR_W-1:0]     addr;
    logic                                   guard;
    logic [2:0]                             sync;
  } host_s;
  host_s st;
  host_s next_st;

  logic                                     cyc_start;
  logic                                     cyc_write;
  logic [flash_guard_pkg::ADDR_W-1:0]       cyc_addr;
  logic [flash_guard_pkg::DATA_W-1:0]       cyc_wdata;
  logic                                     cyc_busy;
  logic                                     cyc_done;
  logic [flash_guard_pkg::DATA_W-1:0]       cyc_rdata;
  logic [2:0]                               last_step;
  logic                                     boot_hit;

  // ==========================================================================
  // Pin cycle engine
  bus_cycle bus_cycle_i (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (cyc_start),
    .is_write   (cyc_write),
    .addr       (cyc_addr),
    .wdata      (cyc_wdata),
    .dq_in      (dq_in),
    .busy       (cyc_busy),
    .done       (cyc_done),
    .rdata      (cyc_rdata),
    .flash_addr (flash_addr),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .chip_en_n  (chip_en_n),
    .write_en_n (write_en_n),
    .out_en_n   (out_en_n)
  );

  // ==========================================================================
  // Boot sector decode, two outermost 8 Kbyte sectors
  always_comb begin
    // 8 Kbyte = 4K words, two sectors span 8K words
    if (top_boot) boot_hit = (req_addr[20:13] == 8'hff);
    else          boot_hit = (req_addr[20:13] == 8'h00);
  end

  // ==========================================================================
  // Command sequences
  always_comb begin
    case (st.op)
      3'd1:    last_step = 3'd3;
      3'd2:    last_step = 3'd2; // Three-cycle enter sequence
      3'd3:    last_step = 3'd3;
      3'd4:    last_step = 3'd4;
      default: last_step = 3'd0;
    endcase
    cyc_write = 1'b1;
    cyc_addr  = {10'h000, flash_guard_pkg::UNLOCK_ADDR1};
    cyc_wdata = {8'h00, flash_guard_pkg::UNLOCK_DATA1};
    if (st.step == 3'd1) begin
      cyc_addr  = {10'h000, flash_guard_pkg::UNLOCK_ADDR2};
      cyc_wdata = {8'h00, flash_guard_pkg::UNLOCK_DATA2};
    end else if (st.step == 3'd2) begin
      case (st.op)
        3'd1:    cyc_wdata = {8'h00, flash_guard_pkg::PROGRAM_CMD}; // Plain program only
        3'd2:    cyc_wdata = {8'h00, flash_guard_pkg::ENTER_REGION};
        3'd3:    cyc_wdata = {8'h00, flash_guard_pkg::EXIT_REGION1};
        default: cyc_wdata = {8'h00, flash_guard_pkg::PROTECT_CMD};
      endcase
    end else if (st.step >= 3'd3) begin
      cyc_addr  = st.addr;
      cyc_wdata = (st.op == 3'd3) ? {8'h00, flash_guard_pkg::EXIT_REGION2} :
                  (st.op == 3'd4) ? {8'h00, flash_guard_pkg::PROTECT_CMD} : st.data;
    end
    if (st.op == 3'd0 || st.op == 3'd5) begin
      cyc_write = 1'b0;
      cyc_addr  = st.addr;
    end
    cyc_start = (st.state == S_SEQ) && !cyc_busy;
  end

  // ==========================================================================
  // Main sequencer
  always_comb begin
    next_st      = st;
    next_st.resp = 1'b0;
    // Guard pin input register for synchronising a level from outside
    next_st.sync = {st.sync[1:0], guard_enable};
    if (st.sync[2] == st.sync[1]) next_st.guard = st.sync[2];
    case (st.state)
      S_POWER: begin
        // First request only after reset; strobes idle high
        next_st.state = S_IDLE;
      end
      S_IDLE: begin
        if (req_valid) begin
          next_st.op      = req_op;
          next_st.addr    = req_addr;
          next_st.data    = req_data;
          next_st.step    = 3'd0;
          next_st.refused = 1'b0;
          next_st.state   = S_SEQ;
          if (req_op == 3'd0 || req_op == 3'd5) next_st.step = 3'd0;
          if (req_op == 3'd1 && st.region && st.locked_fac) begin
            next_st.refused = 1'b1; // Factory region never modified
            next_st.state   = S_DONE;
          end
          if (req_op == 3'd1 && !st.region && !boot_guard_accel_pin && boot_hit) begin
            next_st.refused = 1'b1; // Guarded boot sector
            next_st.state   = S_DONE;
          end
          if (req_op == 3'd5) begin
            next_st.addr = top_boot ? flash_guard_pkg::SERIAL_TOP_BASE
                                    : flash_guard_pkg::SERIAL_BOT_BASE;
          end
        end
      end
      S_SEQ: begin
        if (cyc_start) next_st.state = S_WAIT;
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (!cyc_write) begin
            next_st.data = cyc_rdata;
            if (st.op == 3'd5) begin
              // Indicator bit tells factory lock
              next_st.locked_fac = cyc_rdata[flash_guard_pkg::INDICATOR_BIT];
            end
          end
          if (st.step == last_step || !cyc_write) begin
            next_st.state = S_DONE;
            if (st.op == 3'd2) next_st.region = 1'b1; // Region over boot
            if (st.op == 3'd3) next_st.region = 1'b0; // Exit region, whether locked or not
          end else begin
            next_st.step  = st.step + 3'd1;
            next_st.state = S_SEQ;
          end
        end
      end
      S_DONE: begin
        next_st.resp  = 1'b1;
        next_st.state = S_IDLE;
      end
      default: next_st.state = S_IDLE;
    endcase
  end

  // Region view cleared on reset, as the device does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= '0;
      st.state <= S_POWER;
    end else begin
      st <= next_st;
    end
  end

  assign req_ready            = (st.state == S_IDLE);
  assign resp_valid           = st.resp;
  assign resp_data            = st.data;
  assign refused              = st.refused;
  assign in_region            = st.region;
  assign factory_locked       = st.locked_fac;
  // Guard pin always driven, never left floating
  assign boot_guard_accel_pin = st.guard;
  // Normal high reset level; elevated voltage is never used here
  assign flash_reset_n        = rst_n;

  a_refuse_boot: assert property (@(posedge clk) disable iff (!rst_n)
    (st.state == S_IDLE && req_valid && req_op == 3'd1 && !st.region
     && !boot_guard_accel_pin && !top_boot && req_addr[20:13] == 8'h00)
    |=> refused ##1 resp_valid) else $error("guarded boot write not refused");
  a_region_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (st.state == S_IDLE && req_valid && req_op == 3'd1 && st.region && st.locked_fac)
    |=> st.state == S_DONE) else $error("locked region write issued");
  a_enter_map: assert property (@(posedge clk) disable iff (!rst_n)
    (st.state == S_WAIT && cyc_done && st.op == 3'd2 && st.step == 3'd2)
    |=> in_region) else $error("region not entered");
  a_exit_map: assert property (@(posedge clk) disable iff (!rst_n)
    (st.state == S_WAIT && cyc_done && st.op == 3'd3 && st.step == 3'd3)
    |=> !in_region) else $error("region not exited");
endmodule

// ===== include/flash_guard_pkg.sv
// Package of constants for the flash protection host controller
package flash_guard_pkg;
  // ==========================================================================
  // Geometry
  localparam int ADDR_W          = 21;
  localparam int DATA_W          = 16;
  localparam int SERIAL_WORDS    = 8;
  localparam int REGION_KBYTES   = 64;
  localparam logic [20:0] SERIAL_BOT_BASE = 21'h000000;
  localparam logic [20:0] SERIAL_TOP_BASE = 21'h1f8000;
  localparam int BOOT_SECTOR_KBYTES = 8;

  // ==========================================================================
  // Command sequence words
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2aa;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  ENTER_REGION = 8'h88;
  localparam logic [7:0]  EXIT_REGION1 = 8'h90;
  localparam logic [7:0]  EXIT_REGION2 = 8'h00;
  localparam logic [7:0]  PROTECT_CMD  = 8'h60;
  localparam logic [7:0]  PROGRAM_CMD  = 8'ha0;

  // ==========================================================================
  // Timing
  localparam int CLK_PS          = 4000;
  localparam int STROBE_NS       = 40;
  localparam int GLITCH_NS       = 5;
  localparam int STROBE_CYC      = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int GLITCH_CYC      = (GLITCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PHASE_CYC       = (STROBE_CYC > GLITCH_CYC) ? STROBE_CYC : GLITCH_CYC;
  localparam int PHASE_W         = 5;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PHASE_CYC - 1);
  localparam int INDICATOR_BIT   = 7;
endpackage

// ===== hw/bus_cycle.sv
// One asynchronous flash bus cycle, write or read, with timed strobes
`timescale 1ns/1ps
module bus_cycle (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic                                start,
  input  wire logic                                is_write,
  input  wire logic [flash_guard_pkg::ADDR_W-1:0]  addr,
  input  wire logic [flash_guard_pkg::DATA_W-1:0]  wdata,
  input  wire logic [flash_guard_pkg::DATA_W-1:0]  dq_in,
  output logic                                     busy,
  output logic                                     done,
  output logic [flash_guard_pkg::DATA_W-1:0]       rdata,
  output logic [flash_guard_pkg::ADDR_W-1:0]       flash_addr,
  output logic [flash_guard_pkg::DATA_W-1:0]       dq_out,
  output logic                                     dq_oe,
  output logic                                     chip_en_n,
  output logic                                     write_en_n,
  output logic                                     out_en_n
);
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} phase_e;
  typedef struct packed {
    phase_e                                 ph;
    logic [flash_guard_pkg::PHASE_W-1:0]    cnt;
    logic                                   wr;
    logic                                   done;
    logic [flash_guard_pkg::DATA_W-1:0]     rdata;
    logic [flash_guard_pkg::ADDR_W-1:0]     addr;
    logic [flash_guard_pkg::DATA_W-1:0]     wdata;
    logic                                   ce_n;
    logic                                   we_n;
    logic                                   oe_n;
  } cyc_s;
  cyc_s st;
  cyc_s next_st;

  // ==========================================================================
  // Sequencing
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    case (st.ph)
      IDLE: begin
        if (start) begin
          next_st.ph    = SETUP;
          next_st.wr    = is_write;
          next_st.addr  = addr;
          next_st.wdata = wdata;
          next_st.cnt   = '0;
          next_st.ce_n  = 1'b0;
          // Output enable high before any write strobe
          next_st.oe_n  = is_write;
        end
      end
      SETUP: begin
        next_st.ph   = STROBE;
        next_st.we_n = ~st.wr; // Write only with chip enable low and oe high
      end
      STROBE: begin
        // Strobe held well past the glitch filter width
        if (st.cnt == flash_guard_pkg::PHASE_LAST) begin
          next_st.ph   = HOLD;
          next_st.we_n = 1'b1;
          if (!st.wr) next_st.rdata = dq_in;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      HOLD: begin
        next_st.ph   = IDLE;
        next_st.ce_n = 1'b1;
        next_st.oe_n = 1'b1;
        next_st.done = 1'b1;
      end
      default: next_st.ph = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= '0;
      st.ph   <= IDLE;
      st.ce_n <= 1'b1;
      st.we_n <= 1'b1;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign busy       = (st.ph != IDLE);
  assign done       = st.done;
  assign rdata      = st.rdata;
  assign flash_addr = st.addr;
  assign dq_out     = st.wdata;
  assign dq_oe      = st.wr && (st.ph != IDLE);
  assign chip_en_n  = st.ce_n;
  assign write_en_n = st.we_n;
  assign out_en_n   = st.oe_n;

  a_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(write_en_n) |-> !write_en_n [*2]) else $error("write strobe too short");
  a_write_inhibit: assert property (@(posedge clk) disable iff (!rst_n)
    !write_en_n |-> !chip_en_n && out_en_n) else $error("write strobe with bad enables");
endmodule

// ===== bench/flash_model.sv
// Behavioural flash device with boot guard and secured region
`timescale 1ns/1ps
module flash_model (
  input  wire logic                               flash_reset_n,
  input  wire logic [flash_guard_pkg::ADDR_W-1:0] flash_addr,
  input  wire logic [flash_guard_pkg::DATA_W-1:0] dq_out,
  input  wire logic                               dq_oe,
  input  wire logic                               chip_en_n,
  input  wire logic                               write_en_n,
  input  wire logic                               out_en_n,
  input  wire logic                               boot_guard_accel_pin,
  input  wire logic                               top_boot,
  input  wire logic                               factory,
  output logic [flash_guard_pkg::DATA_W-1:0]      dq_in
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] rmem [logic [20:0]];
  logic [2:0]  step = 3'h0;
  logic        region = 1'b0;
  logic        locked = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [15:0] wd;
  realtime     t_fall = 0;
  // ==========================================================================
  // Protection and read mapping
  function automatic logic prot(input logic [20:0] a);
    logic boot;
    boot = top_boot ? (a[20:13] == 8'hff) : (a[20:13] == 8'h00);
    if (region) return factory || locked;
    return !boot_guard_accel_pin && boot;
  endfunction
  function automatic logic [15:0] rd(input logic [20:0] a);
    logic [20:0] off;
    logic [15:0] v;
    off = a - (top_boot ? 21'h1f8000 : 21'h000000);
    if (region) v = rmem.exists(a) ? rmem[a] : (off < 8 ? 16'h5a00 + off[15:0] : 16'hffff);
    else v = mem.exists(a) ? mem[a] : 16'hffff;
    if (off == 0) v[7] = factory;
    return v;
  endfunction
  // ==========================================================================
  // Write cycles
  always @(negedge write_en_n) t_fall = $realtime;
  always @(posedge write_en_n or negedge flash_reset_n) begin
    wd = dq_oe ? dq_out : ~dq_out;
    if (!flash_reset_n) begin
      step = 3'h0;
      region = 1'b0;
    end else if (!chip_en_n && out_en_n && $realtime - t_fall >= 5.0) begin
      case (step)
        3'h0: step = (wd[7:0] == 8'haa && flash_addr[10:0] == 11'h555) ? 3'h1 : 3'h0;
        3'h1: step = (wd[7:0] == 8'h55 && flash_addr[10:0] == 11'h2aa) ? 3'h2 : 3'h0;
        3'h2: begin
          step = (wd[7:0] == 8'h90) ? 3'h3 : (wd[7:0] == 8'ha0) ? 3'h4 : 3'h0;
          if (wd[7:0] == 8'h88) region = 1'b1;
          if (wd[7:0] == 8'h60 && region) locked = 1'b1;
        end
        3'h3: begin
          if (wd[7:0] == 8'h00) region = 1'b0;
          step = 3'h0;
        end
        default: begin
          if (!prot(flash_addr) && region) rmem[flash_addr] = wd;
          else if (!prot(flash_addr)) mem[flash_addr] = wd;
          step = 3'h0;
        end
      endcase
    end
  end
  // ==========================================================================
  // Read data, inverted last value while released
  always @(flash_addr or chip_en_n or out_en_n or region or top_boot or factory) begin
    if (!chip_en_n && !out_en_n) dq_in = rd(flash_addr);
    else dq_in = ~last;
  end
  always @(posedge out_en_n) last = dq_in;
endmodule

// ===== bench/flash_guard_host_tb_top.sv
// Self-checking testbench for the flash guard host controller
`timescale 1ns/1ps
module flash_guard_host_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [20:0] req_addr = 21'h000000;
  logic [15:0] req_data = 16'h0000;
  logic guard_enable = 1'b1;
  logic top_boot = 1'b0;
  logic factory = 1'b0;
  logic req_ready, resp_valid, refused, in_region, factory_locked, dq_oe;
  logic chip_en_n, write_en_n, out_en_n, boot_guard_accel_pin, flash_reset_n;
  logic [15:0] resp_data, dq_in, dq_out;
  logic [20:0] flash_addr;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  flash_guard_host flash_guard_host_i (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .guard_enable(guard_enable),
    .top_boot(top_boot), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .refused(refused), .in_region(in_region),
    .factory_locked(factory_locked), .flash_addr(flash_addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .chip_en_n(chip_en_n), .write_en_n(write_en_n),
    .out_en_n(out_en_n), .boot_guard_accel_pin(boot_guard_accel_pin),
    .flash_reset_n(flash_reset_n));
  flash_model flash_model_i (
    .flash_reset_n(flash_reset_n), .flash_addr(flash_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .chip_en_n(chip_en_n), .write_en_n(write_en_n),
    .out_en_n(out_en_n), .boot_guard_accel_pin(boot_guard_accel_pin),
    .top_boot(top_boot), .factory(factory), .dq_in(dq_in));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic req(input logic [2:0] op, input logic [20:0] ad, input logic [15:0] d);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = ad;
    req_data = d;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) check("resp_valid", 1'b0, 1'b1);
  endtask
  task automatic guard(input logic g);
    @(negedge clk);
    guard_enable = g;
    repeat (8) @(negedge clk);
    check("guard_pin", boot_guard_accel_pin, g);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check("ce_n", chip_en_n, 1'b1);
    check("we_n", write_en_n, 1'b1);
    check("dq_oe", dq_oe, 1'b0);
    check("in_region", in_region, 1'b0);
    check("req_ready", req_ready, 1'b0);
    check("oe_n", out_en_n, 1'b1);
  endtask
  task automatic t_plain();
    req(3'h1, 21'h040000, 16'h1234);
    check("refused", refused, 1'b0);
    req(3'h0, 21'h040000, 16'h0000);
    check("rdata", resp_data, 16'h1234);
  endtask
  task automatic t_guard(input logic tb);
    logic [20:0] bt, nb;
    top_boot = tb;
    @(negedge clk);
    bt = tb ? 21'h1fe010 : 21'h001ff0;
    nb = tb ? 21'h1fdff0 : 21'h002010;
    @(negedge clk);
    guard(1'b0);
    req(3'h1, bt, 16'h0a0b);
    check("refused", refused, 1'b1);
    req(3'h0, bt, 16'h0000);
    check("rdata", resp_data, 16'hffff);
    req(3'h1, nb, 16'h0c0d);
    check("refused", refused, 1'b0);
    req(3'h0, nb, 16'h0000);
    check("rdata", resp_data, 16'h0c0d);
    guard(1'b1);
    req(3'h1, bt, 16'h0e0f);
    check("refused", refused, 1'b0);
    req(3'h0, bt, 16'h0000);
    check("rdata", resp_data, 16'h0e0f);
  endtask
  task automatic t_region(input logic fac);
    logic [20:0] b;
    logic [20:0] w;
    b = top_boot ? 21'h1f8000 : 21'h000000;
    w = b + (fac ? 21'h00000b : 21'h000009);
    factory = fac;
    req(3'h5, b, 16'h0000);
    check("factory_locked", factory_locked, fac);
    req(3'h2, b, 16'h0000);
    check("in_region", in_region, 1'b1);
    req(3'h0, b + 21'h1, 16'h0000);
    check("serial", resp_data, 16'h5a01);
    req(3'h1, w, 16'h4321);
    check("refused", refused, fac);
    req(3'h0, w, 16'h0000);
    check("rdata", resp_data, fac ? 16'hffff : 16'h4321);
    if (!fac) begin
      req(3'h4, b, 16'h0000);
      check("refused", refused, 1'b0);
      check("in_region", in_region, 1'b1);
      req(3'h1, b + 21'ha, 16'h5555);
      req(3'h0, b + 21'ha, 16'h0000);
      check("rdata", resp_data, 16'hffff);
    end
    req(3'h3, b, 16'h0000);
    check("in_region", in_region, 1'b0);
    req(3'h0, w, 16'h0000);
    check("rdata", resp_data, 16'hffff);
  endtask
  task automatic t_rst_region();
    req(3'h2, 21'h000000, 16'h0000);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("flash_reset_n", flash_reset_n, 1'b0);
    check("req_ready", req_ready, 1'b0);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("in_region", in_region, 1'b0);
    req(3'h0, (top_boot ? 21'h1f8000 : 21'h000000) + 21'h1, 16'h0000);
    check("rdata", resp_data, 16'hffff);
  endtask
  // ==========================================================================
  // Main sequence and timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_plain();
    t_guard(1'b0);
    t_guard(1'b1);
    t_region(1'b0);
    t_region(1'b1);
    t_rst_region();
    wrap_up();
  end
endmodule
